// ### hdl/sfw_pkg.sv
package sfw_pkg;
  // Command codes
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_VWREN = 8'h50;
  localparam logic [7:0] CMD_RDSR1 = 8'h05;
  localparam logic [7:0] CMD_RDSR2 = 8'h35;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_RELID = 8'hab;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_QPP = 8'h32;
  localparam logic [7:0] CMD_SE = 8'h20;
  localparam logic [7:0] CMD_BE32 = 8'h52;
  localparam logic [7:0] CMD_BE64 = 8'hd8;
  localparam logic [7:0] CMD_CE1 = 8'hc7;
  localparam logic [7:0] CMD_CE2 = 8'h60;
  localparam logic [7:0] CMD_SECER = 8'h44;
  localparam logic [7:0] CMD_SECPG = 8'h42;
  // Frame byte counts, code byte included
  localparam logic [2:0] ID_DUMMY_END = 3'h4;
  localparam logic [2:0] ADDR_END = 3'h4;
  localparam logic [2:0] PROG_MIN = 3'h5;
  // Status register one fields
  localparam int SR1_BUSY = 0;
  localparam int SR1_LATCH = 1;
  localparam logic [7:0] SR1_WR_MASK = 8'hfc;
  localparam logic [7:0] SR1_RST = 8'h00;
  // Status register two fields
  localparam int SR2_PROT_HIGH = 0;
  localparam int SR2_QUAD_EN = 1;
  localparam int SR2_COMPL = 6;
  localparam logic [7:0] SR2_WR_MASK = 8'h7f;
  localparam logic [7:0] SR2_LOCK_MASK = 8'h3c;
  localparam logic [7:0] SR2_RST = 8'h00;
  // Security register page addresses
  localparam logic [7:0] SCR_TOP = 8'h00;
  localparam logic [7:0] SCR_PAGE1 = 8'h10;
  localparam logic [7:0] SCR_PAGE2 = 8'h20;
  localparam logic [7:0] SCR_PAGE3 = 8'h30;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int WSR_TIME_US = 10;
  localparam int OP_TIME_US = 20;
  localparam int WSR_CYCLES = WSR_TIME_US * CLK_MHZ;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
  localparam int SCLK_HALF = 16;
  // Arbitrary identifier value, not tied to any part
  localparam logic [7:0] DEV_ID_DEFAULT = 8'h5a;

  function automatic logic sfw_scr_addr_ok(input logic [23:0] a);
    sfw_scr_addr_ok = (a[23:16] == SCR_TOP) &&
      (a[15:8] == SCR_PAGE1 || a[15:8] == SCR_PAGE2 || a[15:8] == SCR_PAGE3);
  endfunction
endpackage

// ### hdl/sfw_if.sv
interface sfw_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic miso_line;

  // Line idles high when nobody drives it
  assign miso_line = miso_oe_n ? 1'b1 : miso;

  modport device (input cs_n, input sclk, input mosi, output miso, output miso_oe_n);
  modport host (output cs_n, output sclk, output mosi, input miso_line);
endinterface

// ### hdl/sfw_device.sv
// What this block does
// - Code 06h sets the write enable latch
// - Program, erase, non-volatile status write need latch set
// - Host frames 06h with chip select, rising edges
// - Code 50h arms volatile write, latch untouched
// - Host sends 50h before status write 01h
// - Code 04h clears the write enable latch
// - Latch clears at reset and operation completion
// - Code 04h also cancels armed volatile write
// - 05h/35h return status, MSB first, falling edges
// - Two 8-bit status registers, fixed fields
// - Status reads accepted even while busy
// - Status byte repeats until chip select rises
// - ABh plus three dummies repeats device identifier
// - Security addresses: 00h, page 10h/20h/30h, byte
// - Busy during program, erase and non-volatile status write
module sfw_device
  import sfw_pkg::*;
#(
  parameter logic [7:0] DEV_ID = DEV_ID_DEFAULT,
  parameter int WSR_CYC = WSR_CYCLES,
  parameter int OP_CYC = OP_CYCLES
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Serial link
  sfw_if.device LINK,
  // Status and command view
  output logic [7:0] STATUS1,
  output logic [7:0] STATUS2,
  output logic CMD_STROBE,
  output logic [7:0] CMD_CODE
);
  typedef enum logic [2:0] {SFW_CMD, SFW_DUMMY, SFW_OUT, SFW_SKIP} sfw_state_type;
  typedef enum logic [1:0] {SFW_SRC_SR1, SFW_SRC_SR2, SFW_SRC_ID} sfw_src_type;

  logic cs_s1, cs_s2, cs_p, ck_s1, ck_s2, ck_p, sin_s1, sin_s2;
  sfw_state_type st_q, st_d;
  sfw_src_type src_q, src_d;
  logic [7:0] cmd_q, cmd_d, sh_q, sh_d, out_q, out_d;
  logic [2:0] bit_q, bit_d, nb_q, nb_d, oidx_q, oidx_d;
  logic [23:0] col_q, col_d;
  logic [7:0] sr1_q, sr1_d, sr2_q, sr2_d;
  logic latch_q, latch_d, busy_q, busy_d, arm_q, arm_d, pwsr_q, pwsr_d;
  logic [15:0] pdat_q, pdat_d;
  logic [15:0] tmr_q, tmr_d;
  logic miso_q, miso_d, oe_n_q, oe_n_d, stb_q, stb_d;
  logic [7:0] code_q, code_d;
  logic cs_rise, ck_rise, ck_fall, sel;
  logic [7:0] byte_in, cur;

  // Pins cross into the clock domain through two flops
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_p <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_p <= 1'b0;
      sin_s1 <= 1'b0;
      sin_s2 <= 1'b0;
    end else begin
      cs_s1 <= LINK.cs_n;
      cs_s2 <= cs_s1;
      cs_p <= cs_s2;
      ck_s1 <= LINK.sclk;
      ck_s2 <= ck_s1;
      ck_p <= ck_s2;
      sin_s1 <= LINK.mosi;
      sin_s2 <= sin_s1;
    end
  end

  assign sel = ~cs_s2;
  assign cs_rise = cs_s2 & ~cs_p;
  assign ck_rise = sel & ck_s2 & ~ck_p;
  assign ck_fall = sel & ~ck_s2 & ck_p;
  assign byte_in = {sh_q[6:0], sin_s2};

  // Status write merge: lock bits are one-time, short write clears register two bits 6, 1 and 0
  function automatic logic [15:0] wsr_merge(input logic [7:0] s1, input logic [7:0] s2,
                                            input logic [15:0] d, input logic two);
    logic [7:0] n1;
    logic [7:0] n2;
    n1 = (s1 & ~SR1_WR_MASK) | (d[15:8] & SR1_WR_MASK);
    n2 = two ? ((s2 & ~SR2_WR_MASK) | (d[7:0] & SR2_WR_MASK)) : s2;
    if (!two) begin
      n2[SR2_COMPL] = 1'b0;
      n2[SR2_QUAD_EN] = 1'b0;
      n2[SR2_PROT_HIGH] = 1'b0;
    end
    n2 = n2 | (s2 & SR2_LOCK_MASK);
    wsr_merge = {n1, n2};
  endfunction

  always_comb begin
    st_d = st_q;
    src_d = src_q;
    cmd_d = cmd_q;
    sh_d = sh_q;
    out_d = out_q;
    bit_d = bit_q;
    nb_d = nb_q;
    oidx_d = oidx_q;
    col_d = col_q;
    sr1_d = sr1_q;
    sr2_d = sr2_q;
    latch_d = latch_q;
    busy_d = busy_q;
    arm_d = arm_q;
    pwsr_d = pwsr_q;
    pdat_d = pdat_q;
    tmr_d = tmr_q;
    miso_d = miso_q;
    oe_n_d = oe_n_q;
    stb_d = 1'b0;
    code_d = code_q;
    cur = (oidx_q == 3'h0) ? (src_q == SFW_SRC_SR1 ? {sr1_q[7:2], latch_q, busy_q} :
                              src_q == SFW_SRC_SR2 ? sr2_q : DEV_ID) : out_q;
    // Self-timed cycle
    if (busy_q) begin
      if (tmr_q == 16'h0001) begin
        busy_d = 1'b0;
        latch_d = 1'b0;
        pwsr_d = 1'b0;
        if (pwsr_q) begin
          {sr1_d, sr2_d} = {pdat_q[15:8], pdat_q[7:0]};
        end
      end
      tmr_d = tmr_q - 16'h0001;
    end
    if (cs_rise) begin
      // Bits of an unfinished code byte never reach the decoder
      if (bit_q == 3'h0 && nb_q != 3'h0 && st_q == SFW_CMD && !busy_q) begin
        stb_d = 1'b1;
        code_d = cmd_q;
        if (cmd_q == CMD_WREN && nb_q == 3'h1) begin
          latch_d = 1'b1;
        end else if (cmd_q == CMD_WRDI && nb_q == 3'h1) begin
          latch_d = 1'b0;
          arm_d = 1'b0;
        end else if (cmd_q == CMD_VWREN && nb_q == 3'h1) begin
          arm_d = 1'b1;
        end else if (cmd_q == CMD_WRSR && (nb_q == 3'h2 || nb_q == 3'h3)) begin
          if (arm_q) begin
            // Volatile update is immediate and never raises busy
            {sr1_d, sr2_d} = wsr_merge(sr1_q, sr2_q, nb_q == 3'h3 ? col_q[15:0] : {col_q[7:0], 8'h00},
                                       nb_q == 3'h3);
            arm_d = 1'b0;
          end else if (latch_q) begin
            pdat_d = wsr_merge(sr1_q, sr2_q, nb_q == 3'h3 ? col_q[15:0] : {col_q[7:0], 8'h00},
                               nb_q == 3'h3);
            pwsr_d = 1'b1;
            busy_d = 1'b1;
            tmr_d = 16'(WSR_CYC);
          end
        end else if (latch_q) begin
          if (((cmd_q == CMD_PP || cmd_q == CMD_QPP) && nb_q >= PROG_MIN) ||
              ((cmd_q == CMD_SE || cmd_q == CMD_BE32 || cmd_q == CMD_BE64) && nb_q == ADDR_END) ||
              ((cmd_q == CMD_CE1 || cmd_q == CMD_CE2) && nb_q == 3'h1) ||
              (cmd_q == CMD_SECER && nb_q == ADDR_END && sfw_scr_addr_ok(col_q)) ||
              (cmd_q == CMD_SECPG && nb_q >= PROG_MIN && sfw_scr_addr_ok(col_q))) begin
            busy_d = 1'b1;
            tmr_d = 16'(OP_CYC);
          end
        end
      end
      st_d = SFW_CMD;
      bit_d = 3'h0;
      nb_d = 3'h0;
      oe_n_d = 1'b1;
    end else if (ck_rise) begin
      sh_d = byte_in;
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        if (nb_q != 3'h7) begin
          nb_d = nb_q + 3'h1;
        end
        if (nb_q == 3'h0) begin
          cmd_d = byte_in;
          oidx_d = 3'h0;
          if (byte_in == CMD_RDSR1 || byte_in == CMD_RDSR2) begin
            st_d = SFW_OUT;
            src_d = (byte_in == CMD_RDSR1) ? SFW_SRC_SR1 : SFW_SRC_SR2;
          end else if (busy_q) begin
            st_d = SFW_SKIP;
          end else if (byte_in == CMD_RELID) begin
            st_d = SFW_DUMMY;
            src_d = SFW_SRC_ID;
          end
        end else begin
          if (nb_q <= 3'h3) begin
            col_d = {col_q[15:0], byte_in};
          end
          if (st_q == SFW_DUMMY && nb_q == ID_DUMMY_END - 3'h1) begin
            st_d = SFW_OUT;
          end
        end
      end
    end else if (ck_fall && st_q == SFW_OUT) begin
      // Source sampled at each byte start so busy polling sees fresh values
      miso_d = cur[7];
      out_d = {cur[6:0], 1'b0};
      oidx_d = oidx_q + 3'h1;
      oe_n_d = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q <= SFW_CMD;
      src_q <= SFW_SRC_SR1;
      cmd_q <= 8'h00;
      sh_q <= 8'h00;
      out_q <= 8'h00;
      bit_q <= 3'h0;
      nb_q <= 3'h0;
      oidx_q <= 3'h0;
      col_q <= 24'h000000;
      sr1_q <= SR1_RST;
      sr2_q <= SR2_RST;
      latch_q <= 1'b0;
      busy_q <= 1'b0;
      arm_q <= 1'b0;
      pwsr_q <= 1'b0;
      pdat_q <= 16'h0000;
      tmr_q <= 16'h0000;
      miso_q <= 1'b1;
      oe_n_q <= 1'b1;
      stb_q <= 1'b0;
      code_q <= 8'h00;
    end else begin
      st_q <= st_d;
      src_q <= src_d;
      cmd_q <= cmd_d;
      sh_q <= sh_d;
      out_q <= out_d;
      bit_q <= bit_d;
      nb_q <= nb_d;
      oidx_q <= oidx_d;
      col_q <= col_d;
      sr1_q <= sr1_d;
      sr2_q <= sr2_d;
      latch_q <= latch_d;
      busy_q <= busy_d;
      arm_q <= arm_d;
      pwsr_q <= pwsr_d;
      pdat_q <= pdat_d;
      tmr_q <= tmr_d;
      miso_q <= miso_d;
      oe_n_q <= oe_n_d;
      stb_q <= stb_d;
      code_q <= code_d;
    end
  end

  // Status view registered so outputs stay glitch free
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      STATUS1 <= SR1_RST;
      STATUS2 <= SR2_RST;
    end else begin
      STATUS1 <= {sr1_q[7:2], latch_q, busy_q};
      STATUS2 <= sr2_q;
    end
  end

  assign LINK.miso = miso_q;
  assign LINK.miso_oe_n = oe_n_q;
  assign CMD_STROBE = stb_q;
  assign CMD_CODE = code_q;
endmodule

// ### hdl/sfw_host.sv
module sfw_host
  import sfw_pkg::*;
#(
  parameter int HALF = SCLK_HALF
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Serial link
  sfw_if.host LINK,
  // Request
  input wire logic GO,
  input wire logic [47:0] TX_BYTES,
  input wire logic [2:0] TX_LEN,
  input wire logic [3:0] RX_LEN,
  // Answer
  output logic BUSY,
  output logic [7:0] RX_BYTE,
  output logic RX_VALID
);
  typedef enum logic [1:0] {SFWH_IDLE, SFWH_LOW, SFWH_HIGH, SFWH_GAP} sfwh_state_type;

  sfwh_state_type st_q, st_d;
  logic [7:0] div_q, div_d;
  logic [6:0] bitn_q, bitn_d, tot_q, tot_d, txb_q, txb_d;
  logic [47:0] tx_q, tx_d;
  logic [7:0] rx_q, rx_d, rxb_q, rxb_d;
  logic cs_q, cs_d, ck_q, ck_d, mo_q, mo_d, rv_q, rv_d, busy_q, busy_d;
  logic mi_s1, mi_s2, tick;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      mi_s1 <= 1'b1;
      mi_s2 <= 1'b1;
    end else begin
      mi_s1 <= LINK.miso_line;
      mi_s2 <= mi_s1;
    end
  end

  // Serial clock made here from the reference clock
  assign tick = (div_q == 8'(HALF - 1));

  always_comb begin
    st_d = st_q;
    div_d = tick ? 8'h00 : div_q + 8'h01;
    bitn_d = bitn_q;
    tot_d = tot_q;
    txb_d = txb_q;
    tx_d = tx_q;
    rx_d = rx_q;
    rxb_d = rxb_q;
    cs_d = cs_q;
    ck_d = ck_q;
    mo_d = mo_q;
    rv_d = 1'b0;
    busy_d = busy_q;
    case (st_q)
      SFWH_IDLE: begin
        div_d = 8'h00;
        if (GO) begin
          // Caller orders 06h or 50h ahead of writes
          st_d = SFWH_LOW;
          cs_d = 1'b0;
          busy_d = 1'b1;
          tx_d = {TX_BYTES[46:0], 1'b0};
          mo_d = TX_BYTES[47];
          bitn_d = 7'h00;
          txb_d = {1'b0, TX_LEN, 3'h0};
          tot_d = 7'({TX_LEN, 3'h0}) + 7'({RX_LEN, 3'h0});
        end
      end
      SFWH_LOW: begin
        if (tick) begin
          if (bitn_q == tot_q) begin
            st_d = SFWH_GAP;
            cs_d = 1'b1;
          end else begin
            st_d = SFWH_HIGH;
            ck_d = 1'b1;
            if (bitn_q >= txb_q) begin
              rx_d = {rx_q[6:0], mi_s2};
              if (bitn_q[2:0] == 3'h7) begin
                rxb_d = {rx_q[6:0], mi_s2};
                rv_d = 1'b1;
              end
            end
            bitn_d = bitn_q + 7'h01;
          end
        end
      end
      SFWH_HIGH: begin
        if (tick) begin
          st_d = SFWH_LOW;
          ck_d = 1'b0;
          mo_d = (bitn_q < txb_q) ? tx_q[47] : 1'b0;
          tx_d = {tx_q[46:0], 1'b0};
        end
      end
      default: begin
        if (tick) begin
          st_d = SFWH_IDLE;
          busy_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q <= SFWH_IDLE;
      div_q <= 8'h00;
      bitn_q <= 7'h00;
      tot_q <= 7'h00;
      txb_q <= 7'h00;
      tx_q <= 48'h000000000000;
      rx_q <= 8'h00;
      rxb_q <= 8'h00;
      cs_q <= 1'b1;
      ck_q <= 1'b0;
      mo_q <= 1'b0;
      rv_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      bitn_q <= bitn_d;
      tot_q <= tot_d;
      txb_q <= txb_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      rxb_q <= rxb_d;
      cs_q <= cs_d;
      ck_q <= ck_d;
      mo_q <= mo_d;
      rv_q <= rv_d;
      busy_q <= busy_d;
    end
  end

  assign LINK.cs_n = cs_q;
  assign LINK.sclk = ck_q;
  assign LINK.mosi = mo_q;
  assign BUSY = busy_q;
  assign RX_BYTE = rxb_q;
  assign RX_VALID = rv_q;
endmodule

// ### tb/sfw_props.sv
module sfw_props
  import sfw_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  // Device view
  input wire logic [7:0] STATUS1,
  input wire logic CMD_STROBE,
  input wire logic [7:0] CMD_CODE
);
  logic sclk_q;
  logic cs_q;
  logic [7:0] bits_q;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // Raw edge count, no synchroniser, so it leads the device's own view
  always_ff @(posedge REF_CLK) begin
    sclk_q <= sclk;
    cs_q <= cs_n;
    if (RST || (cs_q && !cs_n)) begin
      bits_q <= 8'h00;
    end else if (!cs_n && sclk && !sclk_q && bits_q != 8'hff) begin
      bits_q <= bits_q + 8'h01;
    end
  end

  latch_set_a: assert property (CMD_STROBE && CMD_CODE == CMD_WREN |-> ##[1:8] STATUS1[SR1_LATCH])
    else $error("latch not set after enable code");
  latch_clear_a: assert property (CMD_STROBE && CMD_CODE == CMD_WRDI |-> ##[1:8] !STATUS1[SR1_LATCH])
    else $error("latch not cleared after disable code");
  vol_keep_a: assert property (CMD_STROBE && CMD_CODE == CMD_VWREN |-> ##1 $stable(STATUS1[SR1_LATCH]) [*6])
    else $error("volatile enable touched the latch");
  latch_done_a: assert property ($fell(STATUS1[SR1_BUSY]) |-> ##[0:2] !STATUS1[SR1_LATCH])
    else $error("latch still set after cycle end");
  nv_busy_a: assert property (CMD_STROBE && CMD_CODE == CMD_WRSR && STATUS1[SR1_LATCH] &&
    (bits_q == 8'h10 || bits_q == 8'h18) |-> ##[1:8] STATUS1[SR1_BUSY])
    else $error("busy not raised by status write");
  vol_nobusy_a: assert property (CMD_STROBE && CMD_CODE == CMD_WRSR && !STATUS1[SR1_LATCH]
    |-> ##1 !STATUS1[SR1_BUSY] [*8])
    else $error("busy raised without latch");
  frame_bits_a: assert property (CMD_STROBE |-> cs_n && bits_q >= 8'h08)
    else $error("command taken from a short frame");
  miso_idle_a: assert property (cs_n [*8] |-> miso_oe_n)
    else $error("output still driven after deselect");
  miso_shift_a: assert property (!miso_oe_n && $changed(miso) |-> !sclk)
    else $error("output changed while clock high");
  host_edge_a: assert property (sclk && !cs_n |-> $stable(mosi) && $stable(cs_n))
    else $error("input moved around rising clock");

  cover property (CMD_STROBE && CMD_CODE == CMD_WREN);
  cover property ($fell(STATUS1[SR1_BUSY]));
  cover property (!cs_n && !miso_oe_n && sclk);
endmodule

// ### tb/tb_top.sv
module tb_top
  import sfw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identifier value
  localparam logic [7:0] ID_VAL = 8'h3c;
  logic ref_clk;
  logic rst;
  logic go;
  logic [47:0] tx_bytes;
  logic [2:0] tx_len;
  logic [3:0] rx_len;
  logic busy;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] status1;
  logic [7:0] status2;
  logic cmd_strobe;
  logic [7:0] cmd_code;
  logic [7:0] rxq[$];
  int err_total = 0;
  int num_checks = 0;

  sfw_if i_sfw_if();

  // Short operation time so erase and program finish within a few frames
  sfw_device #(.DEV_ID(ID_VAL), .OP_CYC(400)) i_sfw_device (
    .REF_CLK(ref_clk), .RST(rst), .LINK(i_sfw_if.device), .STATUS1(status1),
    .STATUS2(status2), .CMD_STROBE(cmd_strobe), .CMD_CODE(cmd_code));

  sfw_host #(.HALF(16)) i_sfw_host (
    .REF_CLK(ref_clk), .RST(rst), .LINK(i_sfw_if.host), .GO(go), .TX_BYTES(tx_bytes),
    .TX_LEN(tx_len), .RX_LEN(rx_len), .BUSY(busy), .RX_BYTE(rx_byte), .RX_VALID(rx_valid));

  sfw_props i_sfw_props (
    .REF_CLK(ref_clk), .RST(rst), .cs_n(i_sfw_if.cs_n), .sclk(i_sfw_if.sclk),
    .mosi(i_sfw_if.mosi), .miso(i_sfw_if.miso), .miso_oe_n(i_sfw_if.miso_oe_n),
    .STATUS1(status1), .CMD_STROBE(cmd_strobe), .CMD_CODE(cmd_code));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_byte);
    end
  end

  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One whole frame; returns once the host has let go of the link
  task automatic xfer(input logic [47:0] tx, input logic [2:0] tl, input logic [3:0] rl);
    int n;
    rxq.delete();
    @(posedge ref_clk);
    go <= 1'b1;
    tx_bytes <= tx;
    tx_len <= tl;
    rx_len <= rl;
    @(posedge ref_clk);
    go <= 1'b0;
    n = 0;
    @(negedge ref_clk);
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 5000) chk({7'h00, busy}, 8'h00);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (status1[SR1_BUSY] !== 1'b0 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 5000) chk(status1, 8'h00);
  endtask

  initial begin
    rst = 1'b1;
    go = 1'b0;
    tx_bytes = 48'h0;
    tx_len = 3'h0;
    rx_len = 4'h0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk(status1, 8'h00);
    chk(status2, 8'h00);
    xfer({8'h06, 40'h0}, 3'h1, 4'h0);
    chk(status1, 8'h02);
    xfer({8'h05, 40'h0}, 3'h1, 4'h2);
    chk(rxq[0], 8'h02);
    chk(rxq[1], 8'h02);
    xfer({8'h50, 40'h0}, 3'h1, 4'h0);
    chk(status1, 8'h02);
    xfer({8'h04, 40'h0}, 3'h1, 4'h0);
    chk(status1, 8'h00);
    xfer({8'h01, 8'h0c, 8'h02, 24'h0}, 3'h3, 4'h0);
    chk(status1, 8'h00);
    chk(status2, 8'h00);
    xfer({8'h50, 40'h0}, 3'h1, 4'h0);
    xfer({8'h01, 8'h0c, 8'h02, 24'h0}, 3'h3, 4'h0);
    chk(status1, 8'h0c);
    xfer({8'h35, 40'h0}, 3'h1, 4'h1);
    chk(rxq[0], 8'h02);
    // Eight-bit write: also clears the quad enable set above
    xfer({8'h06, 40'h0}, 3'h1, 4'h0);
    xfer({8'h01, 8'h80, 32'h0}, 3'h2, 4'h0);
    xfer({8'h05, 40'h0}, 3'h1, 4'h1);
    chk(rxq[0], 8'h0f);
    wait_idle();
    chk(status1, 8'h80);
    chk(status2, 8'h00);
    xfer({8'hab, 40'h0}, 3'h4, 4'h2);
    chk(rxq[0], ID_VAL);
    chk(rxq[1], ID_VAL);
    for (int p = 1; p < 4; p++) begin
      xfer({8'h06, 40'h0}, 3'h1, 4'h0);
      xfer({8'h44, 8'h00, 4'(p), 4'h0, 24'h0}, 3'h4, 4'h0);
      wait_idle();
      chk(status1, 8'h80);
    end
    xfer({8'h06, 40'h0}, 3'h1, 4'h0);
    xfer({8'h44, 8'h00, 8'h40, 24'h0}, 3'h4, 4'h0);
    chk(status1, 8'h82);
    xfer({8'h02, 24'h0, 8'h55, 8'h00}, 3'h5, 4'h0);
    chk(status1, 8'h83);
    wait_idle();
    chk(status1, 8'h80);
    xfer({8'h02, 24'h0, 8'h55, 8'h00}, 3'h5, 4'h0);
    chk(status1, 8'h80);
    end_of_test();
  end

  // Whole sequence needs about a quarter of this
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end
endmodule
